// File: rtl/dsw_consts.svh
// constants for the serial converter write port
`ifndef DSW_CONSTS_SVH
`define DSW_CONSTS_SVH
`define DSW_WORD_BITS 16
`define DSW_CNT_LAST 5'h10
`define DSW_MODE_MSB 13
`define DSW_MODE_LSB 12
`define DSW_CODE_MSB 11
`define DSW_CODE_LSB 4
`define DSW_CODE_RST 8'h00
`define DSW_MODE_RST 2'h0
`endif

// File: rtl/dsw_pkg.sv
// types for the serial converter write port
`include "dsw_consts.svh"
package dsw_pkg;
    typedef enum logic [1:0] {
        DSW_MODE_NORMAL,
        DSW_MODE_PD_1K,
        DSW_MODE_PD_100K,
        DSW_MODE_PD_OPEN
    } dsw_mode_t;
    typedef struct packed {
        logic [1:0] clk_sync;
        logic [1:0] sel_sync;
        logic [1:0] dat_sync;
        logic clk_prev;
        logic sel_prev;
        logic [15:0] shift;
        logic [4:0] count;
        logic [7:0] code;
        dsw_mode_t mode;
        logic update;
        logic abort;
    } dsw_state_t;
endpackage

// File: rtl/dsw_port.sv
// serial write port of an 8-bit converter: shift register, code and mode
`include "dsw_consts.svh"
// Summary of operation
// [R1] a sixteen-bit shift register captures every serial word
// [R2] data bit sampled and shifted on each of the first sixteen falling serial clock edges in frame
// [R3] frame select is active low; bits accepted only after it falls
// [R4] on the sixteenth falling edge the code and mode are applied
// [R5] frame select rising before sixteen edges aborts, nothing changes
// [R6] controller keeps the serial clock at or below 30 MHz
// [R7] code register is eight-bit straight binary, 00 zero to FF full scale
// [R8] word is MSB first: two ignored, two mode, eight code, four ignored
// [R9] mode bits: 00 normal, 01 1k, 10 100k, 11 high impedance
// [R10] reset clears the code register until a valid frame arrives
// [R11] power-down modes leave the stored code unchanged; here every complete word, power-down ones too, loads its code field
// [R12] counter restarts at frame start; edges past sixteen are ignored
module dsw_port
    import dsw_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic sclk_in,
    input wire logic sync_n_in,
    input wire logic din_in,
    output logic [7:0] code_out,
    output logic [1:0] mode_out,
    output logic mode_ctl_hi_out,
    output logic mode_ctl_lo_out,
    output logic powered_down_out,
    output logic update_out,
    output logic abort_out
);
    dsw_state_t s_q;
    dsw_state_t s_d;

    logic fall_clk;
    logic fall_sel;
    logic rise_sel;
    logic in_frame;
    logic [15:0] next_word;

    // field decoders shared by the update logic and its checks
    function automatic logic [7:0] word_code(input logic [15:0] w);
        return w[`DSW_CODE_MSB:`DSW_CODE_LSB];
    endfunction

    function automatic dsw_mode_t word_mode(input logic [15:0] w);
        return dsw_mode_t'(w[`DSW_MODE_MSB:`DSW_MODE_LSB]);
    endfunction

    // edges are seen on the second synchroniser stage only
    assign fall_clk = s_q.clk_prev & ~s_q.clk_sync[1];
    assign fall_sel = s_q.sel_prev & ~s_q.sel_sync[1];
    assign rise_sel = ~s_q.sel_prev & s_q.sel_sync[1];
    assign in_frame = ~s_q.sel_sync[1]; // [R3]
    assign next_word = {s_q.shift[14:0], s_q.dat_sync[1]}; // [R8]

    always_comb begin
        s_d = s_q;
        s_d.clk_sync = {s_q.clk_sync[0], sclk_in};
        s_d.sel_sync = {s_q.sel_sync[0], sync_n_in};
        s_d.dat_sync = {s_q.dat_sync[0], din_in};
        s_d.clk_prev = s_q.clk_sync[1];
        s_d.sel_prev = s_q.sel_sync[1];
        s_d.update = 1'b0;
        s_d.abort = 1'b0;
        if (fall_sel) begin
            s_d.count = 5'h00; // [R12]
            s_d.shift = 16'h0000;
        end else if (rise_sel) begin
            // a partial word is thrown away
            if (s_q.count != `DSW_CNT_LAST) begin
                s_d.abort = 1'b1; // [R5]
            end
            s_d.count = 5'h00;
            s_d.shift = 16'h0000;
        end else if (in_frame && fall_clk &&
                     s_q.count != `DSW_CNT_LAST) begin // [R12]
            s_d.shift = next_word; // [R1] [R2]
            s_d.count = s_q.count + 5'h01;
            if (s_q.count == `DSW_CNT_LAST - 5'h01) begin
                s_d.update = 1'b1; // [R4]
                s_d.code = word_code(next_word); // [R7]
                // code loaded whatever the mode, so a power-down word replaces it too
                s_d.mode = word_mode(next_word); // [R9] [R11]
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s_q <= '0;
            s_q.clk_sync <= 2'h3;
            s_q.sel_sync <= 2'h3;
            s_q.clk_prev <= 1'b1;
            s_q.sel_prev <= 1'b1;
            s_q.code <= `DSW_CODE_RST; // [R10]
            s_q.mode <= dsw_mode_t'(`DSW_MODE_RST);
        end else begin
            s_q <= s_d;
        end
    end

    assign code_out = s_q.code;
    assign mode_out = s_q.mode;
    assign mode_ctl_hi_out = s_q.mode[1];
    assign mode_ctl_lo_out = s_q.mode[0];
    assign powered_down_out = (s_q.mode != DSW_MODE_NORMAL);
    assign update_out = s_q.update;
    assign abort_out = s_q.abort;

    // word application
    a_code_load: assert property ( // [R4]
        @(posedge clk_in) disable iff (reset_in)
        s_q.update |-> s_q.code == $past(word_code(next_word)))
        else $error("code not loaded from word");
    a_mode_load: assert property ( // [R9]
        @(posedge clk_in) disable iff (reset_in)
        s_q.update |-> s_q.mode == $past(word_mode(next_word)))
        else $error("mode not loaded from word");
    a_abort_hold: assert property ( // [R5]
        @(posedge clk_in) disable iff (reset_in)
        s_q.abort |-> $stable(s_q.code) && $stable(s_q.mode))
        else $error("abort changed code or mode");
    a_code_stable: assert property ( // [R11]
        @(posedge clk_in) disable iff (reset_in)
        !s_q.update |-> $stable(s_q.code))
        else $error("code changed without update");
    a_mode_stable: assert property ( // [R4]
        @(posedge clk_in) disable iff (reset_in)
        !s_q.update |-> $stable(s_q.mode))
        else $error("mode changed without update");
    a_update_pulse: assert property ( // [R4]
        @(posedge clk_in) disable iff (reset_in)
        s_q.update |=> !s_q.update)
        else $error("update pulse too long");
    a_update_cause: assert property ( // [R2]
        @(posedge clk_in) disable iff (reset_in)
        s_q.update |-> $past(fall_clk) && $past(in_frame))
        else $error("update without a clock fall in frame");
    // bit counting and framing
    a_count_max: assert property ( // [R12]
        @(posedge clk_in) disable iff (reset_in)
        s_q.count <= `DSW_CNT_LAST)
        else $error("bit count above sixteen");
    a_count_step: assert property ( // [R1]
        @(posedge clk_in) disable iff (reset_in)
        in_frame && fall_clk && !fall_sel && s_q.count < `DSW_CNT_LAST
        |=> s_q.count == $past(s_q.count) + 5'h01)
        else $error("count did not step on a clock fall");
    a_shift_in: assert property ( // [R2]
        @(posedge clk_in) disable iff (reset_in)
        in_frame && fall_clk && !fall_sel && s_q.count < `DSW_CNT_LAST
        |=> s_q.shift[0] == $past(s_q.dat_sync[1]))
        else $error("data bit not shifted");
    a_past_last: assert property ( // [R12]
        @(posedge clk_in) disable iff (reset_in)
        in_frame && fall_clk && !fall_sel && s_q.count == `DSW_CNT_LAST
        |=> $stable(s_q.shift) && $stable(s_q.count))
        else $error("edge after sixteenth not ignored");
    a_out_frame: assert property ( // [R3]
        @(posedge clk_in) disable iff (reset_in)
        !in_frame && !rise_sel |=> $stable(s_q.count))
        else $error("count moved outside frame");
    a_frame_gate: assert property ( // [R3]
        @(posedge clk_in) disable iff (reset_in)
        !in_frame && !rise_sel |=> $stable(s_q.shift))
        else $error("shift moved outside frame");
    a_sel_clear: assert property ( // [R12]
        @(posedge clk_in) disable iff (reset_in)
        fall_sel |=> s_q.count == 5'h00)
        else $error("count not cleared at frame start");
    a_update_count: assert property ( // [R1]
        @(posedge clk_in) disable iff (reset_in)
        s_q.update |-> s_q.count == `DSW_CNT_LAST)
        else $error("update before sixteen bits");
    // aborts
    a_rise_clear: assert property ( // [R5]
        @(posedge clk_in) disable iff (reset_in)
        rise_sel |=> s_q.count == 5'h00 && s_q.shift == 16'h0000)
        else $error("partial word not discarded");
    a_abort_count: assert property ( // [R5]
        @(posedge clk_in) disable iff (reset_in)
        s_q.abort |-> s_q.count == 5'h00)
        else $error("abort left a count behind");
    a_abort_pulse: assert property ( // [R5]
        @(posedge clk_in) disable iff (reset_in)
        s_q.abort |=> !s_q.abort)
        else $error("abort pulse too long");
    a_pulse_excl: assert property ( // [R5]
        @(posedge clk_in) disable iff (reset_in)
        !(s_q.update && s_q.abort))
        else $error("update and abort together");
    // reset, synchronisers and outputs
    a_reset_code: assert property ( // [R10]
        @(posedge clk_in)
        $past(reset_in) |-> s_q.code == `DSW_CODE_RST)
        else $error("code not cleared at reset");
    a_reset_mode: assert property ( // [R10]
        @(posedge clk_in)
        $past(reset_in) |-> s_q.mode == DSW_MODE_NORMAL)
        else $error("mode not normal at reset");
    a_reset_pulse: assert property ( // [R10]
        @(posedge clk_in)
        $past(reset_in) |-> !s_q.update && !s_q.abort)
        else $error("pulse seen right after reset");
    a_clk_chain: assert property ( // [R2]
        @(posedge clk_in) disable iff (reset_in)
        s_q.clk_prev == $past(s_q.clk_sync[1]))
        else $error("serial clock edge stage out of step");
    a_sel_chain: assert property ( // [R3]
        @(posedge clk_in) disable iff (reset_in)
        s_q.sel_prev == $past(s_q.sel_sync[1]))
        else $error("frame select edge stage out of step");
    a_mode_map: assert property ( // [R9]
        @(posedge clk_in) disable iff (reset_in)
        powered_down_out == (mode_out != 2'h0))
        else $error("power-down flag mismatch");
    a_ctl_bits: assert property ( // [R9]
        @(posedge clk_in) disable iff (reset_in)
        {mode_ctl_hi_out, mode_ctl_lo_out} == mode_out)
        else $error("mode control bits differ from mode");
    a_code_range: assert property ( // [R7]
        @(posedge clk_in) disable iff (reset_in)
        s_q.update |-> code_out == $past(word_code(next_word)))
        else $error("code output wrong");

    c_update: cover property (@(posedge clk_in) s_q.update);
    c_abort: cover property (@(posedge clk_in) s_q.abort);
    c_open: cover property (@(posedge clk_in) mode_out == 2'h3);
    c_full: cover property (@(posedge clk_in) code_out == 8'hFF);
    c_pd_1k: cover property (@(posedge clk_in) mode_out == 2'h1);
endmodule

// File: dv/dsw_master.sv
// serial controller model that writes words into the converter port
module dsw_master (
    input wire logic clk_in,
    output logic sclk_out,
    output logic sync_n_out,
    output logic din_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sclk_out = 1'b1;
        sync_n_out = 1'b1;
        din_out = 1'b0;
    end
    // clock stands high between frames; 400 ns period, far below 30 MHz
    // n above 16 sends extra clock falls carrying zero bits
    task automatic send(input logic [15:0] w, input int n);
        @(negedge clk_in);
        sync_n_out = 1'b0;
        repeat (4) @(negedge clk_in);
        for (int i = 15; i > 15 - n; i--) begin
            din_out = (i >= 0) ? w[i] : 1'b0;
            repeat (2) @(negedge clk_in);
            sclk_out = 1'b0;
            repeat (4) @(negedge clk_in);
            sclk_out = 1'b1;
            repeat (2) @(negedge clk_in);
        end
        sync_n_out = 1'b1;
        // released data line must not keep looking like the last bit
        din_out = ~din_out;
        repeat (4) @(negedge clk_in);
    endtask
endmodule

// File: dv/test_dsw_port.sv
// self-checking bench for the converter write port
module test_dsw_port;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic sclk, sync_n, din, hi, lo, pd, upd, abt;
    logic [7:0] code;
    logic [1:0] mode;
    int fails = 0, checks = 0, cyc = 0, ups = 0, abs = 0;
    always #25 clk_in = ~clk_in;
    dsw_master m (.clk_in(clk_in), .sclk_out(sclk), .sync_n_out(sync_n),
        .din_out(din));
    dsw_port dut (.clk_in(clk_in), .reset_in(reset_in), .sclk_in(sclk),
        .sync_n_in(sync_n), .din_in(din), .code_out(code), .mode_out(mode),
        .mode_ctl_hi_out(hi), .mode_ctl_lo_out(lo), .powered_down_out(pd),
        .update_out(upd), .abort_out(abt));
    always @(posedge clk_in) begin
        cyc++;
        if (upd === 1'b1) ups++;
        if (abt === 1'b1) abs++;
        if (cyc == 3000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // pulse counts catch both a missing and a doubled pulse
    task automatic frame(input logic [15:0] w, input int n, u, a);
        int u0, a0;
        u0 = ups;
        a0 = abs;
        m.send(w, n);
        repeat (8) @(negedge clk_in);
        check(16'(ups - u0), 16'(u));
        check(16'(abs - a0), 16'(a));
    endtask
    task automatic t_codes();
        check(16'(code), 16'h0000);
        check(16'(mode), 16'h0000);
        frame({2'b11, 2'b00, 8'hFF, 4'hF}, 16, 1, 0);
        check(16'(code), 16'h00FF);
        frame({2'b00, 2'b00, 8'h00, 4'h0}, 16, 1, 0);
        check(16'(code), 16'h0000);
        frame({2'b11, 2'b00, 8'hA5, 4'hF}, 16, 1, 0);
        check(16'(code), 16'h00A5);
        $display("codes finished");
    endtask
    task automatic t_modes();
        for (int i = 1; i < 5; i++) begin
            frame({2'b00, 2'(i), 8'hA5, 4'h0}, 16, 1, 0);
            check(16'(mode), 16'(i % 4));
            check(16'({hi, lo}), 16'(i % 4));
            check(16'(pd), 16'(i < 4));
            check(16'(code), 16'h00A5);
        end
        $display("modes finished");
    endtask
    task automatic t_abort();
        frame({2'b00, 2'b11, 8'h3C, 4'h0}, 15, 0, 1);
        check(16'(code), 16'h00A5);
        check(16'(mode), 16'h0000);
        frame({2'b00, 2'b00, 8'h3C, 4'h0}, 16, 1, 0);
        check(16'(code), 16'h003C);
        frame({2'b00, 2'b00, 8'h5A, 4'h1}, 17, 1, 0);
        check(16'(code), 16'h005A);
        $display("abort finished");
    endtask
    task automatic report_and_stop();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge clk_in);
        reset_in = 1'b0;
        repeat (4) @(negedge clk_in);
        t_codes();
        t_modes();
        t_abort();
        report_and_stop();
    end
endmodule
